// ---- src/emp_port_map.vh ----
// Purpose: constants for the external memory port
// Assumes: 125 MHz clk_sys, one clock domain
// Notes:   access timing counts are in clk_sys cycles
//
// Overview of operation
// - sixteen three-state address lines carry every external access address
// - address holds its last value when no external space is accessed
// - twenty-four line bidirectional data bus for program and data memory
// - data bus stays high impedance while bus grant is asserted with arbitration mode clear
// - program select asserted only during external program memory accesses
// - data select asserted only during external data memory accesses
// - space selector shows X or Y during data accesses
// - read strobe asserted so external memory drives the data bus
// - write strobe asserted while write data is driven
// - control outputs high impedance while reset is applied
// - arbitration mode clear: request releases port after current access completes
// - arbitration mode clear: grant asserted only after the port is released
// - arbitration mode set: request input acts as wait, stretching access
// - arbitration mode set: grant output acts as strobe during accesses
`ifndef EMP_PORT_MAP_VH
`define EMP_PORT_MAP_VH

// ==========================================================
// widths and encodings
`define EMP_ADDR_W      16
`define EMP_DATA_W      24
`define EMP_SPACE_PROG  2'h0
`define EMP_SPACE_X     2'h1
`define EMP_SPACE_Y     2'h2
`define EMP_MODE_BIT    7
`define EMP_ADDR_RST    16'h0000
`define EMP_DATA_RST    24'h00_0000

// ==========================================================
// timing: strobe width per access
`define EMP_STROBE_NS   16
`define EMP_CLK_NS      8
`define EMP_STROBE_CYC  ((`EMP_STROBE_NS + `EMP_CLK_NS - 1) / `EMP_CLK_NS)

`endif

// ---- src/emp_sync.v ----
// Purpose: two-flop synchroniser for a pin level
// Assumes: input asynchronous to clk_sys
// Notes:   first flop feeds only the second
`timescale 1ns/100ps
module emp_sync #(
    parameter RST_VAL = 1'b1
) (
    input  wire clk_sys,
    input  wire rst_n,
    input  wire din,
    output wire dout
);
    reg meta_q;
    reg sync_q;

    // ==========================================================
    // synchroniser stages
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;
endmodule

// ---- src/emp_port.v ----
// Purpose: external memory port sequencer with bus arbitration
// Assumes: core issues one access at a time on acc_req / acc_done
// Notes:   pin strobes active low; three-state as value + enable
`timescale 1ns/100ps
`include "emp_port_map.vh"
module emp_port #(
    parameter ADDR_W     = `EMP_ADDR_W,
    parameter DATA_W     = `EMP_DATA_W,
    parameter STROBE_CYC = `EMP_STROBE_CYC
) (
    input  wire              clk_sys,
    input  wire              rst_n,
    // core side
    input  wire              acc_req,
    input  wire              acc_write,
    input  wire [1:0]        acc_space,
    input  wire [ADDR_W-1:0] acc_addr,
    input  wire [DATA_W-1:0] acc_wdata,
    input  wire [7:0]        operating_mode_reg,
    output reg               acc_busy,
    output reg               acc_done,
    output reg  [DATA_W-1:0] acc_rdata,
    // pins
    output reg  [ADDR_W-1:0] ext_addr,
    output reg               ext_addr_oe,
    input  wire [DATA_W-1:0] ext_data_in,
    output reg  [DATA_W-1:0] ext_data_out,
    output reg               ext_data_oe,
    output reg               prog_space_sel_n,
    output reg               data_space_sel_n,
    output reg               space_x_y,
    output reg               rd_strobe_n,
    output reg               wr_strobe_n,
    output reg               ctrl_oe,
    input  wire              bus_request_in_n,
    output reg               bus_grant_out_n,
    output reg               bus_grant_oe
);
    localparam ST_IDLE = 2'b00;
    localparam ST_ACC  = 2'b01;
    localparam ST_REL  = 2'b10;

    reg [1:0]  state_q;
    reg [3:0]  cnt_q;
    reg        oe_seen_q;
    wire       req_sync_n;
    wire       arb_wait;
    wire       strobe_done;

    // request pin is asynchronous, synchronise before use
    emp_sync #(.RST_VAL(1'b1)) u_req_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .din     (bus_request_in_n),
        .dout    (req_sync_n)
    );

    assign arb_wait    = operating_mode_reg[`EMP_MODE_BIT];
    // in wait mode an asserted request stretches the strobe
    assign strobe_done = (cnt_q >= STROBE_CYC[3:0]) && !(arb_wait && !req_sync_n);

    // ==========================================================
    // access sequencer
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q          <= ST_IDLE;
            cnt_q            <= 4'h0;
            oe_seen_q        <= 1'b0;
            acc_busy         <= 1'b0;
            acc_done         <= 1'b0;
            acc_rdata        <= `EMP_DATA_RST;
            ext_addr         <= `EMP_ADDR_RST;
            ext_addr_oe      <= 1'b0;
            ext_data_out     <= `EMP_DATA_RST;
            ext_data_oe      <= 1'b0;
            prog_space_sel_n <= 1'b1;
            data_space_sel_n <= 1'b1;
            space_x_y        <= 1'b1;
            rd_strobe_n      <= 1'b1;
            wr_strobe_n      <= 1'b1;
            ctrl_oe          <= 1'b0;  // released while in reset
            bus_grant_out_n  <= 1'b1;
            bus_grant_oe     <= 1'b0;
        end else begin
            acc_done     <= 1'b0;
            bus_grant_oe <= 1'b1;
            oe_seen_q    <= 1'b1;
            case (state_q)
                ST_IDLE: begin
                    if (!arb_wait && !req_sync_n) begin
                        // idle counts as instruction boundary, so release now
                        ext_addr_oe <= 1'b0;
                        ext_data_oe <= 1'b0;
                        ctrl_oe     <= 1'b0;
                        acc_busy    <= 1'b1;
                        state_q     <= ST_REL;
                    end else if (acc_req) begin
                        acc_busy         <= 1'b1;
                        ext_addr_oe      <= 1'b1;
                        ctrl_oe          <= 1'b1;
                        ext_addr         <= acc_addr;
                        // exactly one select per access
                        prog_space_sel_n <= (acc_space != `EMP_SPACE_PROG);
                        data_space_sel_n <= (acc_space == `EMP_SPACE_PROG);
                        space_x_y        <= (acc_space != `EMP_SPACE_Y);
                        rd_strobe_n      <= acc_write;
                        wr_strobe_n      <= !acc_write;
                        ext_data_out     <= acc_wdata;
                        ext_data_oe      <= acc_write;
                        bus_grant_out_n  <= !arb_wait;
                        cnt_q            <= 4'h1;
                        state_q          <= ST_ACC;
                    end else begin
                        acc_busy <= 1'b0;
                        // address left as is to save toggling
                        ext_addr_oe <= oe_seen_q;
                        ctrl_oe     <= oe_seen_q;
                    end
                end
                ST_ACC: begin
                    if (strobe_done) begin
                        acc_rdata        <= ext_data_in;
                        acc_done         <= 1'b1;
                        acc_busy         <= 1'b0;
                        prog_space_sel_n <= 1'b1;
                        data_space_sel_n <= 1'b1;
                        rd_strobe_n      <= 1'b1;
                        wr_strobe_n      <= 1'b1;
                        ext_data_oe      <= 1'b0;
                        bus_grant_out_n  <= 1'b1;
                        cnt_q            <= 4'h0;
                        state_q          <= ST_IDLE;
                    end else if (cnt_q < STROBE_CYC[3:0]) begin
                        cnt_q <= cnt_q + 4'h1;
                    end
                end
                ST_REL: begin
                    // grant only once pins are already released
                    bus_grant_out_n <= req_sync_n || ctrl_oe;
                    if (req_sync_n || arb_wait) begin
                        bus_grant_out_n <= 1'b1;
                        acc_busy        <= 1'b0;
                        state_q         <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
endmodule

// ---- verif/emp_port_properties.sv ----
// Purpose: pin checker for emp_port
// Assumes: mode bit moves only between accesses
// Notes:   bound below by wildcard names
`timescale 1ns/100ps
module emp_port_properties #(parameter ADDR_W = 16) (
    input wire              clk_sys,
    input wire              rst_n,
    input wire [1:0]        acc_space,
    input wire              acc_done,
    input wire [7:0]        operating_mode_reg,
    input wire [ADDR_W-1:0] ext_addr,
    input wire              ext_addr_oe,
    input wire              ext_data_oe,
    input wire              prog_space_sel_n,
    input wire              data_space_sel_n,
    input wire              space_x_y,
    input wire              rd_strobe_n,
    input wire              wr_strobe_n,
    input wire              ctrl_oe,
    input wire              bus_grant_out_n
);
    // ========
    // pin relations; m1 is wait/strobe mode
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire m1 = operating_mode_reg[7];
    rw_excl_a: assert property (rd_strobe_n || wr_strobe_n) else $error("rd wr");
    sel_excl_a: assert property (prog_space_sel_n || data_space_sel_n) else $error("sel");
    addr_hold_a: assert property ($changed(ext_addr) |->
        !(prog_space_sel_n && data_space_sel_n)) else $error("addr");
    wr_drive_a: assert property (!wr_strobe_n |-> ext_data_oe) else $error("wr");
    rd_float_a: assert property (!rd_strobe_n |-> !ext_data_oe) else $error("rd");
    rd_len_a: assert property (!m1 && $fell(rd_strobe_n) |->
        ##1 !rd_strobe_n ##1 (rd_strobe_n && acc_done)) else $error("rd len");
    psel_space_a: assert property ($fell(prog_space_sel_n) |->
        $past(acc_space) == 2'h0) else $error("ps");
    dsel_space_a: assert property ($fell(data_space_sel_n) |->
        space_x_y == ($past(acc_space) == 2'h1)) else $error("ds");
    grant_float_a: assert property (!m1 && !bus_grant_out_n |->
        !ctrl_oe && !ext_addr_oe && !ext_data_oe) else $error("gnt");
    grant_late_a: assert property (!m1 && $fell(bus_grant_out_n) |->
        !$past(ctrl_oe)) else $error("gnt late");
    strobe_m1_a: assert property (m1 && $stable(operating_mode_reg) &&
        !(rd_strobe_n && wr_strobe_n) |-> !bus_grant_out_n) else $error("bs");
    rst_float_a: assert property (disable iff (1'b0) !rst_n |->
        !ctrl_oe && !ext_addr_oe && !ext_data_oe) else $error("rst");
    cover property (!m1 && $fell(bus_grant_out_n));
    cover property (m1 && acc_done);
    cover property (!wr_strobe_n);
endmodule
bind emp_port emp_port_properties #(.ADDR_W(ADDR_W)) emp_port_properties_i (.*);

// ---- verif/emp_mem_model.sv ----
// Purpose: external memory behind the port
// Assumes: 64 words keyed by space and low address
// Notes:   idle read bus shows inverted last word
`timescale 1ns/100ps
module emp_mem_model (
    input  wire         clk_sys,
    input  wire  [15:0] ext_addr,
    input  wire         prog_space_sel_n,
    input  wire         space_x_y,
    input  wire         rd_strobe_n,
    input  wire         wr_strobe_n,
    input  wire  [23:0] ext_data_out,
    output logic [23:0] ext_data_in
);
    // ========
    // storage; inverted idle value so stale data never passes
    logic [23:0] mem [64];
    logic [23:0] last_q = 24'h0;
    wire  [5:0]  key = prog_space_sel_n ? {1'b1, space_x_y, ext_addr[3:0]} : {2'h0, ext_addr[3:0]};
    initial foreach (mem[k]) mem[k] = 24'h0;
    always @(posedge clk_sys) if (!wr_strobe_n) mem[key] <= ext_data_out;
    always @(posedge clk_sys) if (!rd_strobe_n) last_q <= mem[key];
    always @* ext_data_in = rd_strobe_n ? ~last_q : mem[key];
endmodule

// ---- verif/testbench.sv ----
// Purpose: self-checking bench for emp_port
// Assumes: inputs move on the falling edge
// Notes:   shadow copy keyed like the memory model
`timescale 1ns/100ps
module testbench;
    logic        clk_sys, rst_n, acc_req, acc_write, acc_busy, acc_done, ext_addr_oe;
    logic        ext_data_oe, prog_space_sel_n, data_space_sel_n, space_x_y, ctrl_oe;
    logic        rd_strobe_n, wr_strobe_n, bus_request_in_n, bus_grant_out_n, bus_grant_oe;
    logic [1:0]  acc_space;
    logic [7:0]  operating_mode_reg;
    logic [15:0] acc_addr, ext_addr;
    logic [23:0] acc_wdata, acc_rdata, ext_data_in, ext_data_out, exp_q [64];
    integer      miscompares = 0, n_compared = 0, seed = 32'hac15, lat, i;
    emp_port emp_port_i (.*);
    emp_mem_model emp_mem_model_i (.*);
    // ========
    // clock; watchdog far beyond the few hundred cycles needed
    initial begin
        clk_sys = 0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial begin
        #200000;
        miscompares++;
        stop_test;
    end
    function automatic [5:0] key(input logic [1:0] sp, input logic [15:0] a);
        key = (sp == 2'h0) ? {2'h0, a[3:0]} : {1'b1, sp == 2'h1, a[3:0]};
    endfunction
    task cmp(input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task stop_test;
        if (miscompares == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // one access held until done, bounded wait
    task acc(input logic w, input logic [1:0] sp, input logic [15:0] a, input logic [23:0] d);
        @(negedge clk_sys);
        {acc_req, acc_write, acc_space, acc_addr, acc_wdata} = {1'b1, w, sp, a, d};
        lat = 0;
        do begin
            @(negedge clk_sys);
            lat++;
        end while (acc_done !== 1'b1 && lat < 60);
        acc_req = 0;
        // a hung access counts as a mismatch; busy must drop with done
        cmp({22'h0, acc_done, acc_busy}, 24'h2);
        if (w) exp_q[key(sp, a)] = d;
        else cmp(acc_rdata, exp_q[key(sp, a)]);
        cmp({8'h00, ext_addr}, {8'h00, a});
    endtask
    // main sequence
    initial begin
        {rst_n, acc_req, acc_write, acc_space, acc_addr, acc_wdata} = '0;
        operating_mode_reg = 8'h00;
        bus_request_in_n = 1;
        foreach (exp_q[k]) exp_q[k] = 24'h0;
        repeat (6) @(negedge clk_sys);
        cmp({20'h0, bus_grant_oe, ctrl_oe, ext_addr_oe, ext_data_oe}, 24'h0);
        rst_n = 1;
        // reads 3..5 revisit the words written by 0..2
        for (i = 0; i < 6; i++) acc(i < 3, 2'(i % 3), (i % 3 == 1) ? 16'hffff : 16'h0,
                                   24'hff_ffff - 24'(i % 3));
        for (i = 0; i < 50; i++) begin
            operating_mode_reg = 8'($random(seed));
            acc(1'($random(seed)), 2'($unsigned($random(seed)) % 3), 16'($random(seed)),
                24'($random(seed)));
        end
        repeat (5) @(negedge clk_sys);
        cmp({8'h00, ext_addr}, {8'h00, acc_addr});
        operating_mode_reg = 8'h00;
        fork
            acc(1, 2'h1, 16'h0005, 24'h12_3456);
            @(negedge clk_sys) bus_request_in_n = 0;
        join
        repeat (8) @(negedge clk_sys);
        cmp({20'h0, bus_grant_out_n, ctrl_oe, ext_addr_oe, ext_data_oe}, 24'h0);
        bus_request_in_n = 1;
        repeat (8) @(negedge clk_sys);
        cmp({22'h0, bus_grant_out_n, ctrl_oe}, 24'h3);
        operating_mode_reg = 8'h80;
        bus_request_in_n = 0;
        fork
            acc(0, 2'h1, 16'h0005, 24'h0);
            begin
                repeat (6) @(negedge clk_sys);
                bus_request_in_n = 1;
            end
        join
        cmp({23'h0, lat > 6}, 24'h1);
        stop_test;
    end
endmodule
